// ==== include/tsi_pkg.sv ====
package tsi_pkg;

  localparam int unsigned CLOCK_HZ       = 100_000_000;
  localparam int unsigned INIT_MS        = 1000;
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned FLASH_PAUSE_MS = 1000;
  localparam int unsigned INIT_CYCLES    = INIT_MS * (CLOCK_HZ / 1000);
  localparam int unsigned HALF_CYCLES    = FLASH_HALF_MS * (CLOCK_HZ / 1000);
  localparam int unsigned PAUSE_CYCLES   = FLASH_PAUSE_MS * (CLOCK_HZ / 1000);

  localparam int unsigned SWITCH_W = 8;
  localparam int unsigned DIGIT_W  = 4;

  localparam logic [3:0] CODE_LOW_POWER  = 4'h2;
  localparam logic [3:0] CODE_INPUT_ERR  = 4'h4;
  localparam logic [3:0] CODE_SW_STANDBY = 4'h5;
  localparam logic [3:0] CODE_SW_TX      = 4'h6;

  typedef enum logic [5:0] {
    TSI_INIT      = 6'h01,
    TSI_CARD_ERR  = 6'h02,
    TSI_INPUT_ERR = 6'h04,
    TSI_STANDBY   = 6'h08,
    TSI_TX        = 6'h10,
    TSI_SW_ERR    = 6'h20
  } tsi_state_t;

endpackage : tsi_pkg

// ==== rtl/tsi_status_indicator.sv ====
`timescale 1ns/10ps
module tsi_status_indicator #(
  parameter int unsigned INIT_CYCLES  = tsi_pkg::INIT_CYCLES,
  parameter int unsigned HALF_CYCLES  = tsi_pkg::HALF_CYCLES,
  parameter int unsigned PAUSE_CYCLES = tsi_pkg::PAUSE_CYCLES
) (
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire logic                         supplyOk,
  input  wire logic                         cardReadOk,
  input  wire logic                         inputsIdle,
  input  wire logic                         safetyActive,
  input  wire logic                         restartButton,
  input  wire logic                         restartManual,
  input  wire logic [tsi_pkg::SWITCH_W-1:0] configSwitches,
  input  wire logic                         channelConfigMode,
  input  wire logic [tsi_pkg::DIGIT_W-1:0]  channelUnits,
  input  wire logic [tsi_pkg::DIGIT_W-1:0]  channelTens,
  input  wire logic                         channelLowPowerBad,
  output logic                              greenStatusLamp,
  output logic                              redStatusLamp,
  output logic                              supplyPresentLamp,
  output logic                              radioTxEnable
);

  logic       rstSync1_q;
  logic       rstSync2_q;
  logic       rst_n;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rst_n = rstSync2_q;

  tsi_pkg::tsi_state_t             state_q, state_d;
  logic [31:0]                     timer_q, timer_d;
  logic [tsi_pkg::SWITCH_W-1:0]    swRef_q, swRef_d;
  logic                            safetyPrev_q, safetyPrev_d;
  logic                            clearArmed_q, clearArmed_d;
  logic                            txFlash_q, txFlash_d;
  logic [31:0]                     txCnt_q, txCnt_d;
  logic [3:0]                      errCode_q, errCode_d;

  always_comb begin
    state_d      = state_q;
    timer_d      = timer_q;
    swRef_d      = swRef_q;
    safetyPrev_d = safetyActive;
    clearArmed_d = clearArmed_q;
    errCode_d    = errCode_q;
    txCnt_d      = txCnt_q + 32'h1;
    txFlash_d    = txFlash_q;
    if (txCnt_q >= HALF_CYCLES - 1) begin
      txCnt_d   = 32'h0;
      txFlash_d = !txFlash_q;
    end
    case (state_q)
      tsi_pkg::TSI_INIT: begin
        timer_d = timer_q + 32'h1;
        swRef_d = configSwitches;
        if (timer_q >= INIT_CYCLES - 1) begin
          timer_d = 32'h0;
          if (!cardReadOk) begin
            state_d = tsi_pkg::TSI_CARD_ERR;
          end else if (!inputsIdle) begin
            state_d = tsi_pkg::TSI_INPUT_ERR;
          // auto restart goes straight on air
          end else if (!restartManual && safetyActive) begin
            state_d = tsi_pkg::TSI_TX;
          end else begin
            state_d = tsi_pkg::TSI_STANDBY;
          end
        end
      end
      tsi_pkg::TSI_CARD_ERR,
      tsi_pkg::TSI_INPUT_ERR: begin
        // Only a fresh power-up leaves these faults
        state_d = state_q;
      end
      tsi_pkg::TSI_STANDBY: begin
        // manual wait for the restart button
        if (safetyActive && (restartButton || !restartManual)) begin
          state_d = tsi_pkg::TSI_TX;
        end
      end
      tsi_pkg::TSI_TX: begin
        // safety drop forces a new restart
        if (!safetyActive) begin
          state_d = tsi_pkg::TSI_STANDBY;
        end
      end
      tsi_pkg::TSI_SW_ERR: begin
        // restore switches, then activate and deactivate safety
        if (configSwitches != swRef_q) begin
          clearArmed_d = 1'b0;
        end else if (safetyActive && !safetyPrev_q) begin
          clearArmed_d = 1'b1;
        end else if (!safetyActive && safetyPrev_q && clearArmed_q) begin
          clearArmed_d = 1'b0;
          state_d      = tsi_pkg::TSI_STANDBY;
        end
      end
      default: begin
        state_d = tsi_pkg::TSI_INIT;
      end
    endcase
    if ((state_q == tsi_pkg::TSI_STANDBY || state_q == tsi_pkg::TSI_TX) &&
        configSwitches != swRef_q) begin
      state_d      = tsi_pkg::TSI_SW_ERR;
      clearArmed_d = 1'b0;
      errCode_d    = (state_q == tsi_pkg::TSI_TX) ? tsi_pkg::CODE_SW_TX
                                                  : tsi_pkg::CODE_SW_STANDBY;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= tsi_pkg::TSI_INIT;
      timer_q      <= 32'h0;
      swRef_q      <= '0;
      safetyPrev_q <= 1'b0;
      clearArmed_q <= 1'b0;
      txFlash_q    <= 1'b0;
      txCnt_q      <= 32'h0;
      errCode_q    <= 4'h0;
    end else begin
      state_q      <= state_d;
      timer_q      <= timer_d;
      swRef_q      <= swRef_d;
      safetyPrev_q <= safetyPrev_d;
      clearArmed_q <= clearArmed_d;
      txFlash_q    <= txFlash_d;
      txCnt_q      <= txCnt_d;
      errCode_q    <= errCode_d;
    end
  end

  // Pulse counts for the two flash engines: index 0 green, index 1 red
  logic [3:0] flashCode [2];
  logic       engineOn  [2];
  logic       useCodes;

  always_comb begin
    useCodes     = 1'b1;
    flashCode[0] = 4'h0;
    flashCode[1] = 4'h0;
    case (state_q)
      tsi_pkg::TSI_INPUT_ERR: begin
        flashCode[0] = tsi_pkg::CODE_INPUT_ERR;
        flashCode[1] = tsi_pkg::CODE_INPUT_ERR;
      end
      tsi_pkg::TSI_SW_ERR: begin
        flashCode[0] = errCode_q;
        flashCode[1] = errCode_q;
      end
      tsi_pkg::TSI_STANDBY,
      tsi_pkg::TSI_TX: begin
        if (channelConfigMode && channelLowPowerBad) begin
          flashCode[0] = tsi_pkg::CODE_LOW_POWER;
          flashCode[1] = tsi_pkg::CODE_LOW_POWER;
        end else if (channelConfigMode) begin
          // units on green, tens on red
          flashCode[0] = channelUnits;
          flashCode[1] = channelTens;
        end else begin
          useCodes = 1'b0;
        end
      end
      default: begin
        useCodes = 1'b0;
      end
    endcase
  end

  for (genvar i = 0; i < 2; i++) begin : gEngine
    logic [31:0] cnt_q, cnt_d;
    logic [4:0]  idx_q, idx_d;
    logic [3:0]  code_q;
    logic [4:0]  twice;

    // N pulses of equal on and off, then a long pause
    always_comb begin
      twice = {code_q, 1'b0};
      cnt_d = cnt_q + 32'h1;
      idx_d = idx_q;
      if (flashCode[i] != code_q) begin
        // Restart the pattern so a new code is never shown mid-count
        cnt_d = 32'h0;
        idx_d = 5'h0;
      end else if (idx_q >= twice) begin
        if (cnt_q >= PAUSE_CYCLES - 1) begin
          cnt_d = 32'h0;
          idx_d = 5'h0;
        end
      end else if (cnt_q >= HALF_CYCLES - 1) begin
        cnt_d = 32'h0;
        idx_d = idx_q + 5'h1;
      end
      // Dark on the restart cycle so an old pulse never merges with the first new one
      engineOn[i] = (flashCode[i] == code_q) && (idx_q < twice) && !idx_q[0];
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q  <= 32'h0;
        idx_q  <= 5'h0;
        code_q <= 4'h0;
      end else begin
        cnt_q  <= cnt_d;
        idx_q  <= idx_d;
        code_q <= flashCode[i];
      end
    end
  end

  logic greenLamp_d;
  logic redLamp_d;

  always_comb begin
    greenLamp_d = 1'b0;
    redLamp_d   = 1'b0;
    if (useCodes) begin
      greenLamp_d = engineOn[0];
      redLamp_d   = engineOn[1];
    end else begin
      case (state_q)
        tsi_pkg::TSI_INIT: redLamp_d = 1'b1;
        tsi_pkg::TSI_CARD_ERR: begin
          greenLamp_d = 1'b1;
          redLamp_d   = 1'b1;
        end
        tsi_pkg::TSI_STANDBY: greenLamp_d = 1'b1;
        tsi_pkg::TSI_TX: greenLamp_d = txFlash_q;
        default: begin
          greenLamp_d = 1'b0;
          redLamp_d   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      greenStatusLamp   <= 1'b0;
      redStatusLamp     <= 1'b0;
      supplyPresentLamp <= 1'b0;
      radioTxEnable     <= 1'b0;
    end else begin
      greenStatusLamp   <= greenLamp_d;
      redStatusLamp     <= redLamp_d;
      supplyPresentLamp <= supplyOk;
      radioTxEnable     <= (state_d == tsi_pkg::TSI_TX);
    end
  end

endmodule : tsi_status_indicator

// ==== verif/transmitter_status_indicator_test.sv ====
`timescale 1ns/10ps
module transmitter_status_indicator_test;
  localparam int HALF = 4;
  localparam int PAUSE = 12;
  logic clock, reset_n, supplyOk, cardReadOk, inputsIdle, restartManual, pressReq;
  logic channelConfigMode, channelLowPowerBad, safetyReq, restartButton, safetyActive;
  logic greenStatusLamp, redStatusLamp, supplyPresentLamp, radioTxEnable;
  logic [tsi_pkg::SWITCH_W-1:0] switchReq, configSwitches;
  logic [3:0] channelUnits, channelTens;
  int err_count, tests_run, seed;
  tsi_status_indicator #(.INIT_CYCLES(20), .HALF_CYCLES(HALF), .PAUSE_CYCLES(PAUSE)) dut (
    .clock, .reset_n, .supplyOk, .cardReadOk, .inputsIdle, .safetyActive,
    .restartButton, .restartManual, .configSwitches, .channelConfigMode,
    .channelUnits, .channelTens, .channelLowPowerBad, .greenStatusLamp,
    .redStatusLamp, .supplyPresentLamp, .radioTxEnable);
  tsi_operator_model op (.clock, .pressReq, .safetyReq, .switchReq, .restartButton,
    .safetyActive, .configSwitches);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    finish_test();
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic lamps(input logic [1:0] e);
    check({6'h00, greenStatusLamp, redStatusLamp}, {6'h00, e});
  endtask : lamps
  function automatic int period(input int n);
    return n * 2 * HALF + PAUSE;
  endfunction : period
  task automatic waitTx(input logic lvl);
    int n;
    n = 0;
    while (radioTxEnable !== lvl && n < 40) begin
      cyc(1);
      n++;
    end
    check({7'h00, radioTxEnable}, {7'h00, lvl});
    if (n == 40) finish_test();
  endtask : waitTx
  task automatic boot(input logic man, input logic card, input logic idle);
    reset_n = 1'b0;
    restartManual = man;
    cardReadOk = card;
    // Normally-open inputs idle unless a fault is wanted
    inputsIdle = idle;
    cyc(3);
    reset_n = 1'b1;
    cyc(8);
    lamps(2'h1);
    cyc(20);
  endtask : boot
  // Any full period holds exactly N rising edges whatever its phase
  task automatic flashes(input int gExp, input int rExp);
    logic [7:0] g, r;
    logic pg, pr;
    g = 8'h00;
    r = 8'h00;
    cyc(3);
    pg = greenStatusLamp;
    pr = redStatusLamp;
    for (int i = 0; i < period(gExp) || i < period(rExp); i++) begin
      cyc(1);
      if (i < period(gExp) && greenStatusLamp === 1'b1 && pg === 1'b0) g++;
      if (i < period(rExp) && redStatusLamp === 1'b1 && pr === 1'b0) r++;
      pg = greenStatusLamp;
      pr = redStatusLamp;
    end
    check(g, 8'(gExp));
    check(r, 8'(rExp));
  endtask : flashes
  initial begin
    seed = 32'hfe7b;
    reset_n = 1'b0;
    supplyOk = 1'b1;
    channelConfigMode = 1'b0;
    channelLowPowerBad = 1'b0;
    channelUnits = 4'h0;
    channelTens = 4'h0;
    pressReq = 1'b0;
    safetyReq = 1'b1;
    switchReq = 8'h5a;
    boot(1'b1, 1'b1, 1'b1);
    lamps(2'h2);
    check({7'h00, supplyPresentLamp}, 8'h01);
    pressReq = 1'b1;
    cyc(1);
    pressReq = 1'b0;
    waitTx(1'b1);
    channelConfigMode = 1'b1;
    for (int k = 0; k < 4; k++) begin
      channelUnits = (k == 0) ? 4'h0 : 4'($unsigned($random(seed)) % 10);
      channelTens = (k == 0) ? 4'h9 : 4'($unsigned($random(seed)) % 10);
      flashes(channelUnits, channelTens);
    end
    channelLowPowerBad = 1'b1;
    flashes(2, 2);
    check({7'h00, radioTxEnable}, 8'h01);
    channelConfigMode = 1'b0;
    channelLowPowerBad = 1'b0;
    switchReq = 8'ha5;
    flashes(6, 6);
    pressReq = 1'b1;
    cyc(1);
    pressReq = 1'b0;
    cyc(5);
    check({7'h00, radioTxEnable}, 8'h00);
    switchReq = 8'h5a;
    safetyReq = 1'b0;
    cyc(3);
    safetyReq = 1'b1;
    cyc(3);
    safetyReq = 1'b0;
    cyc(5);
    lamps(2'h2);
    safetyReq = 1'b1;
    switchReq = 8'h01;
    flashes(5, 5);
    $display("manual restart sequence ends");
    switchReq = 8'h5a;
    boot(1'b0, 1'b1, 1'b1);
    waitTx(1'b1);
    safetyReq = 1'b0;
    waitTx(1'b0);
    safetyReq = 1'b1;
    waitTx(1'b1);
    $display("auto restart sequence ends");
    boot(1'b1, 1'b0, 1'b1);
    lamps(2'h3);
    cyc(40);
    lamps(2'h3);
    boot(1'b1, 1'b1, 1'b0);
    flashes(4, 4);
    supplyOk = 1'b0;
    cyc(3);
    check({7'h00, supplyPresentLamp}, 8'h00);
    $display("fault sequence ends");
    finish_test();
  end
endmodule : transmitter_status_indicator_test

// ==== verif/tsi_operator_model.sv ====
`timescale 1ns/10ps
module tsi_operator_model (
  input  wire logic                         clock,
  input  wire logic                         pressReq,
  input  wire logic                         safetyReq,
  input  wire logic [tsi_pkg::SWITCH_W-1:0] switchReq,
  output logic                              restartButton,
  output logic                              safetyActive,
  output logic [tsi_pkg::SWITCH_W-1:0]      configSwitches
);
  logic [1:0] holdCnt;
  initial holdCnt = 2'h0;
  // A hand press lasts a few cycles, not one
  // Sampled on the rising edge so the bench's falling-edge requests never race
  always @(posedge clock) begin
    holdCnt <= pressReq ? 2'h3 : (holdCnt != 2'h0) ? holdCnt - 2'h1 : 2'h0;
    restartButton <= pressReq || (holdCnt > 2'h1);
    // Safety and switches follow the operator
    safetyActive <= safetyReq;
    configSwitches <= switchReq;
  end
endmodule : tsi_operator_model

// ==== verif/tsi_status_indicator_assertions.sv ====
`timescale 1ns/10ps
module tsi_status_indicator_assertions #(
  parameter int unsigned INIT_CYCLES = 20,
  parameter int unsigned HALF_CYCLES = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic supplyOk,
  input wire logic safetyActive,
  input wire logic restartButton,
  input wire logic restartManual,
  input wire logic channelConfigMode,
  input wire logic greenStatusLamp,
  input wire logic redStatusLamp,
  input wire logic supplyPresentLamp,
  input wire logic radioTxEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [31:0] upCnt_q, runCnt_q, txCnt_q;
  logic        lastGreen_q;
  // Counters give the window after reset, the length of each green lamp phase and the time in transmission outside channel config mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      upCnt_q <= 32'h0;
      runCnt_q <= 32'h0;
      txCnt_q <= 32'h0;
      lastGreen_q <= 1'b0;
    end else begin
      upCnt_q <= (upCnt_q < INIT_CYCLES + 8) ? upCnt_q + 32'h1 : upCnt_q;
      runCnt_q <= (greenStatusLamp == lastGreen_q) ? runCnt_q + 32'h1 : 32'h1;
      lastGreen_q <= greenStatusLamp;
      txCnt_q <= (radioTxEnable && !channelConfigMode) ? txCnt_q + 32'h1 : 32'h0;
    end
  end
  property p_supply;
    upCnt_q > 4 && supplyOk |-> ##[1:2] supplyPresentLamp;
  endproperty
  a_supply: assert property (p_supply) else $error("supply lamp dark");
  property p_init;
    upCnt_q > 5 && upCnt_q < INIT_CYCLES |-> redStatusLamp && !greenStatusLamp;
  endproperty
  a_init: assert property (p_init) else $error("init lamps wrong");
  property p_redTx;
    radioTxEnable && $past(radioTxEnable) && !channelConfigMode
      && !$past(channelConfigMode) |-> !redStatusLamp;
  endproperty
  a_redTx: assert property (p_redTx) else $error("red lit in transmission");
  property p_txDrop;
    radioTxEnable && !safetyActive |=> !radioTxEnable;
  endproperty
  a_txDrop: assert property (p_txDrop) else $error("tx kept without safety");
  property p_txRise;
    $rose(radioTxEnable) |-> $past(safetyActive)
      && ($past(restartButton) || !$past(restartManual));
  endproperty
  a_txRise: assert property (p_txRise) else $error("tx started without cause");
  property p_flash;
    txCnt_q > HALF_CYCLES + 3 |-> runCnt_q <= HALF_CYCLES;
  endproperty
  a_flash: assert property (p_flash) else $error("green not flashing");
  // Only meaningful while a flash is shorter than the eight-cycle window
  property p_cardHold;
    HALF_CYCLES < 8 ##0 (greenStatusLamp && redStatusLamp)[*8]
      |=> greenStatusLamp && redStatusLamp;
  endproperty
  a_cardHold: assert property (p_cardHold) else $error("card fault cleared");
  property p_cardNoTx;
    HALF_CYCLES < 8 ##0 (greenStatusLamp && redStatusLamp)[*8] |-> !radioTxEnable;
  endproperty
  a_cardNoTx: assert property (p_cardNoTx) else $error("tx during card fault");
  c_tx: cover property ($rose(radioTxEnable));
  c_card: cover property ((greenStatusLamp && redStatusLamp)[*8]);
  c_show: cover property (radioTxEnable && channelConfigMode);
endmodule : tsi_status_indicator_assertions
bind tsi_status_indicator tsi_status_indicator_assertions #(
  .INIT_CYCLES(INIT_CYCLES), .HALF_CYCLES(HALF_CYCLES)) u_chk (.clock, .reset_n,
  .supplyOk, .safetyActive, .restartButton, .restartManual, .channelConfigMode,
  .greenStatusLamp, .redStatusLamp, .supplyPresentLamp, .radioTxEnable);
